// ==== hdl/efa_pkg.sv ====
package efa_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_INCR_HI = 16'h4082;
   localparam logic [15:0] IDX_INCR_LO = 16'h4083;
   localparam logic [15:0] IDX_THRESH_HI = 16'h4084;
   localparam logic [15:0] IDX_THRESH_LO = 16'h4085;
   localparam logic [15:0] IDX_CEIL_HI = 16'h4086;
   localparam logic [15:0] IDX_CEIL_LO = 16'h4087;
   localparam logic [15:0] IDX_K3_HI = 16'h4088;
   localparam logic [15:0] IDX_K3_LO = 16'h4089;
   localparam logic [15:0] IDX_K4_HI = 16'h408A;
   localparam logic [15:0] IDX_K4_LO = 16'h408B;
   localparam logic [15:0] IDX_K1_HI = 16'h408C;
   localparam logic [15:0] IDX_K1_LO = 16'h408D;
   localparam logic [15:0] IDX_K2_HI = 16'h408E;
   localparam logic [15:0] IDX_K2_LO = 16'h408F;
   localparam logic [15:0] IDX_CTRL = 16'h40A0;
   localparam logic [15:0] IDX_STAT = 16'h40A1;

   // ---------------------------------------------------------------
   // parameter slots, counted in pairs from the first index
   // ---------------------------------------------------------------
   localparam int NUM_SLOTS = 7;
   localparam logic [2:0] SLOT_INCR = 3'h0;
   localparam logic [2:0] SLOT_THRESH = 3'h1;
   localparam logic [2:0] SLOT_CEIL = 3'h2;
   localparam logic [2:0] SLOT_K3 = 3'h3;
   localparam logic [2:0] SLOT_K4 = 3'h4;
   localparam logic [2:0] SLOT_K1 = 3'h5;
   localparam logic [2:0] SLOT_K2 = 3'h6;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   // one bit per slot: set where bit 15 is writable
   localparam logic [6:0] MSB_RW_MASK = 7'h17;

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] PRM_RESET = 16'h0000;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_FORCED_BIT = 0;
   localparam int STAT_CEIL_BIT = 1;
   localparam int FRAC_BITS = 8;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int CTRL_PERIOD_NS = 1000;
   localparam int TICK_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] thresh;
      logic [15:0] ceiling;
      logic [15:0] incr;
      logic [15:0] k1;
      logic [15:0] k2;
      logic [15:0] k3;
      logic [15:0] k4;
   } efa_params_t;

   typedef enum logic {EFA_BUS_IDLE, EFA_BUS_WAIT} efa_bus_state_t;

endpackage

// ==== hdl/efa_ahb_slave.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// ahb-lite front end: one wait state on every transfer
// ---------------------------------------------------------------
module efa_ahb_slave (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic acc_wr,
   output logic [31:0] acc_addr,
   output logic [7:0] acc_wdata,
   input wire logic [7:0] acc_rdata
);

   efa_pkg::efa_bus_state_t state;
   logic pend_write;

   // address phase taken only when the bus is ready and the slot is active
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= efa_pkg::EFA_BUS_IDLE;
         hreadyout <= 1'b1;
         pend_write <= 1'b0;
         acc_addr <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
      end else begin
         case (state)
            efa_pkg::EFA_BUS_IDLE: begin
               if (hsel && hready && htrans[1]) begin
                  state <= efa_pkg::EFA_BUS_WAIT;
                  hreadyout <= 1'b0;
                  pend_write <= hwrite;
                  acc_addr <= haddr;
               end
            end
            efa_pkg::EFA_BUS_WAIT: begin
               // the wait state lets read data come from a flop
               state <= efa_pkg::EFA_BUS_IDLE;
               hreadyout <= 1'b1;
               hrdata <= pend_write ? 32'h0000_0000 : {24'h00_0000, acc_rdata};
            end
            default: begin
               state <= efa_pkg::EFA_BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   // the response is always okay; unmapped words read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // write lands in the wait cycle, while hwdata stands
   assign acc_wr = (state == efa_pkg::EFA_BUS_WAIT) && pend_write;
   assign acc_wdata = hwdata[7:0];

endmodule // efa_ahb_slave

// ==== hdl/efa_forced_ramp.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// forced speed ramp and forced angle integrator
// ---------------------------------------------------------------
module efa_forced_ramp (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic run,
   input wire logic signed [23:0] incr,
   input wire logic signed [23:0] ceiling,
   output logic signed [23:0] speed,
   output logic [15:0] angle,
   output logic at_ceiling
);

   logic signed [24:0] next_sum;

   // one guard bit so the sum cannot wrap before the clamp
   assign next_sum = 25'(speed) + 25'(incr);

   // speed climbs by the increment each period, never past the ceiling
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         speed <= 24'h00_0000;
         at_ceiling <= 1'b0;
      end else if (tick) begin
         if (next_sum >= 25'(ceiling)) begin
            speed <= ceiling;
            at_ceiling <= 1'b1;
         end else begin
            speed <= next_sum[23:0];
            at_ceiling <= 1'b0;
         end
      end
   end

   // angle advances by the integer part of the speed; wraps by design
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         angle <= 16'h0000;
      end else if (tick) begin
         angle <= angle + speed[23:8];
      end
   end

endmodule // efa_forced_ramp

// ==== hdl/efa_regs.sv ====
`timescale 1ns/10ps
// Contract
// - threshold is 24-bit signed, software writes top 16
// - forced angle out when enabled and speed below threshold
// - threshold scaled base speed 32768, signed 16-bit range
// - ceiling 24-bit signed, upper 16; forced speed clamped
// - ceiling accepts full signed 16-bit range
// - coefficients one to three: bit 15 reads zero
// - coefficient four fully writable signed
// - forced speed raised by 24-bit increment, low 16 written

// ---------------------------------------------------------------
// estimator forced-angle parameters and angle selection
// ---------------------------------------------------------------
module efa_regs #(
   parameter int TICK_DIV = efa_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic signed [23:0] est_speed,
   input wire logic [15:0] est_angle,
   output logic [15:0] angle_out,
   output logic forced_active,
   output logic ctrl_tick,
   output efa_pkg::efa_params_t params
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic acc_wr;
   logic [31:0] acc_addr;
   logic [7:0] acc_wdata;
   logic [7:0] acc_rdata;
   logic [15:0] prm [0:efa_pkg::NUM_SLOTS-1];
   logic [7:0] ctrl;
   logic [15:0] idx;
   logic [2:0] slot;
   logic word_ok;
   logic [15:0] cnt;
   logic tick;
   logic signed [23:0] thresh24;
   logic signed [23:0] ceil24;
   logic signed [23:0] incr24;
   logic signed [23:0] f_speed;
   logic [15:0] f_angle;
   logic f_at_ceil;
   logic sel_forced;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // maps an index to its parameter slot, or none
   function automatic logic [2:0] slot_of(input logic [15:0] i);
      logic [15:0] d;
      d = i - efa_pkg::IDX_INCR_HI;
      if (i >= efa_pkg::IDX_INCR_HI && i <= efa_pkg::IDX_K2_LO) begin
         slot_of = d[3:1];
      end else begin
         slot_of = efa_pkg::SLOT_NONE;
      end
   endfunction

   // widens a 16-bit field to the 24-bit internal form
   function automatic logic [23:0] to_internal(input logic [15:0] v);
      to_internal = {v, 8'h00};
   endfunction

   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   efa_ahb_slave u_bus (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .acc_wr(acc_wr),
      .acc_addr(acc_addr),
      .acc_wdata(acc_wdata),
      .acc_rdata(acc_rdata)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // only aligned words inside the low index space are mapped
   assign idx = acc_addr[17:2];
   assign word_ok = (acc_addr[31:18] == 14'h0000) && (acc_addr[1:0] == 2'h0);
   assign slot = word_ok ? slot_of(idx) : efa_pkg::SLOT_NONE;

   // ---------------------------------------------------------------
   // parameter storage
   // ---------------------------------------------------------------
   // even index carries the high byte, odd index the low byte
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int s = 0; s < efa_pkg::NUM_SLOTS; s++) begin
            prm[s] <= efa_pkg::PRM_RESET;
         end
      end else if (acc_wr && slot != efa_pkg::SLOT_NONE) begin
         if (!idx[0]) begin
            // bit 15 only sticks where the slot allows it
            prm[slot][15] <= acc_wdata[7] & efa_pkg::MSB_RW_MASK[slot];
            prm[slot][14:8] <= acc_wdata[6:0];
         end else begin
            prm[slot][7:0] <= acc_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // bit 0 turns the forced-angle mode on
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= efa_pkg::CTRL_RESET;
      end else if (acc_wr && word_ok && idx == efa_pkg::IDX_CTRL) begin
         ctrl <= {7'h00, acc_wdata[efa_pkg::CTRL_EN_BIT]};
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // unmapped and reserved bits read as zero
   always_comb begin
      acc_rdata = 8'h00;
      if (slot != efa_pkg::SLOT_NONE) begin
         acc_rdata = idx[0] ? prm[slot][7:0] : prm[slot][15:8];
      end else if (word_ok && idx == efa_pkg::IDX_CTRL) begin
         acc_rdata = ctrl;
      end else if (word_ok && idx == efa_pkg::IDX_STAT) begin
         acc_rdata[efa_pkg::STAT_FORCED_BIT] = forced_active;
         acc_rdata[efa_pkg::STAT_CEIL_BIT] = f_at_ceil;
      end
   end

   // ---------------------------------------------------------------
   // parameters out to the estimator
   // ---------------------------------------------------------------
   // the stored words are themselves flops, so no extra stage
   assign params.thresh = prm[efa_pkg::SLOT_THRESH];
   assign params.ceiling = prm[efa_pkg::SLOT_CEIL];
   assign params.incr = prm[efa_pkg::SLOT_INCR];
   assign params.k1 = prm[efa_pkg::SLOT_K1];
   assign params.k2 = prm[efa_pkg::SLOT_K2];
   assign params.k3 = prm[efa_pkg::SLOT_K3];
   assign params.k4 = prm[efa_pkg::SLOT_K4];

   // ---------------------------------------------------------------
   // control period divider
   // ---------------------------------------------------------------
   // one-cycle enable per control period instead of a second clock
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 16'h0000;
         ctrl_tick <= 1'b0;
      end else if (cnt == 16'(TICK_DIV - 1)) begin
         cnt <= 16'h0000;
         ctrl_tick <= 1'b1;
      end else begin
         cnt <= cnt + 16'h0001;
         ctrl_tick <= 1'b0;
      end
   end

   assign tick = ctrl_tick;

   // ---------------------------------------------------------------
   // internal 24-bit forms
   // ---------------------------------------------------------------
   // written bits sit high for threshold and ceiling, low for increment
   assign thresh24 = to_internal(prm[efa_pkg::SLOT_THRESH]);
   assign ceil24 = to_internal(prm[efa_pkg::SLOT_CEIL]);
   assign incr24 = {8'h00, prm[efa_pkg::SLOT_INCR]};

   // ---------------------------------------------------------------
   // forced ramp
   // ---------------------------------------------------------------
   // ramp restarts from zero whenever the mode is switched off
   efa_forced_ramp u_ramp (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .run(ctrl[efa_pkg::CTRL_EN_BIT]),
      .incr(incr24),
      .ceiling(ceil24),
      .speed(f_speed),
      .angle(f_angle),
      .at_ceiling(f_at_ceil)
   );

   // ---------------------------------------------------------------
   // angle selection
   // ---------------------------------------------------------------
   // signed compare: a negative threshold never forces a positive speed
   assign sel_forced = ctrl[efa_pkg::CTRL_EN_BIT] && (est_speed < thresh24);

   // registered so the angle output comes from a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         angle_out <= 16'h0000;
         forced_active <= 1'b0;
      end else begin
         angle_out <= sel_forced ? f_angle : est_angle;
         forced_active <= sel_forced;
      end
   end

endmodule // efa_regs

// ==== tb/efa_regs_properties.sv ====
`timescale 1ns/10ps
module efa_regs_properties #(
   parameter int TICK_DIV = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic signed [23:0] est_speed,
   input wire logic [15:0] est_angle,
   input wire logic [15:0] angle_out,
   input wire logic forced_active,
   input wire logic ctrl_tick,
   input wire efa_pkg::efa_params_t params
);
   // -----------------------------------------
   // transfer shapes
   // -----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   function automatic logic [31:0] ba(logic [15:0] i);
      return {14'h0000, i, 2'b00};
   endfunction
   sequence s_take(logic w, logic [31:0] a);
      hsel && hready && htrans[1] && (hwrite == w) && (haddr == a);
   endsequence
   // address phase, then the single wait cycle
   sequence s_xfer(logic w, logic [31:0] a);
      s_take(w, a) ##1 !hreadyout;
   endsequence
   // -----------------------------------------
   // properties
   // -----------------------------------------
   property p_thresh_wr;
      s_xfer(1'b1, ba(efa_pkg::IDX_THRESH_HI)) |=> ##1 params.thresh[15:8] == $past(hwdata[7:0]);
   endproperty
   property p_ceil_wr;
      s_xfer(1'b1, ba(efa_pkg::IDX_CEIL_LO)) |=> ##1 params.ceiling[7:0] == $past(hwdata[7:0]);
   endproperty
   property p_k4_wr;
      s_xfer(1'b1, ba(efa_pkg::IDX_K4_HI)) |=> ##1 params.k4[15:8] == $past(hwdata[7:0]);
   endproperty
   property p_incr_wr;
      s_xfer(1'b1, ba(efa_pkg::IDX_INCR_LO)) |=> ##1 params.incr[7:0] == $past(hwdata[7:0]);
   endproperty
   property p_k1_wr;
      s_xfer(1'b1, ba(efa_pkg::IDX_K1_HI)) |=> ##1 params.k1[15:8] == {1'b0, $past(hwdata[6:0])};
   endproperty
   property p_coef_msb;
      !params.k1[15] && !params.k2[15] && !params.k3[15];
   endproperty
   property p_thresh_rd;
      s_xfer(1'b0, ba(efa_pkg::IDX_THRESH_LO)) |=> ##1 hrdata == {24'h00_0000, params.thresh[7:0]};
   endproperty
   property p_one_wait;
      hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout;
   endproperty
   property p_fa_cause;
      forced_active |-> $past(est_speed) < $signed({$past(params.thresh), 8'h00});
   endproperty
   property p_est_pass;
      !forced_active && !$past(rst) |-> angle_out == $past(est_angle);
   endproperty
   a_thresh_wr: assert property (p_thresh_wr)
      else $error("threshold high byte not stored");
   a_ceil_wr: assert property (p_ceil_wr)
      else $error("ceiling low byte not stored");
   a_k4_wr: assert property (p_k4_wr)
      else $error("coefficient four high byte not stored");
   a_incr_wr: assert property (p_incr_wr)
      else $error("increment low byte not stored");
   a_k1_wr: assert property (p_k1_wr)
      else $error("coefficient one high byte wrong");
   a_coef_msb: assert property (p_coef_msb)
      else $error("coefficient top bit set");
   a_thresh_rd: assert property (p_thresh_rd)
      else $error("threshold low byte read wrong");
   a_one_wait: assert property (p_one_wait)
      else $error("bus wait shape wrong");
   a_fa_cause: assert property (p_fa_cause)
      else $error("forced angle without low speed");
   a_est_pass: assert property (p_est_pass)
      else $error("estimated angle not passed");
endmodule // efa_regs_properties

bind efa_regs efa_regs_properties #(.TICK_DIV(TICK_DIV)) u_props (.clk(clk), .rst(rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .est_speed(est_speed), .est_angle(est_angle), .angle_out(angle_out),
   .forced_active(forced_active), .ctrl_tick(ctrl_tick), .params(params));

// ==== tb/tb_efa_regs.sv ====
`timescale 1ns/10ps
module tb_efa_regs;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready, hreadyout, hresp, forced_active, ctrl_tick;
   logic [31:0] hrdata;
   logic signed [23:0] est_speed = 24'h00_0000;
   logic [15:0] est_angle = 16'h0000;
   logic [15:0] angle_out, idx;
   logic [7:0] d;
   efa_pkg::efa_params_t params;
   logic [31:0] exp_q[$];
   logic [31:0] rnd = 32'h0000_f012;
   logic rd_pend = 1'b0;
   int bad_count = 0;
   int comparisons = 0;

   // -----------------------------------------
   // clock, bus ready and the block
   // -----------------------------------------
   always #20 clk = ~clk;
   assign hready = hreadyout; // single slave on the bus
   efa_regs #(.TICK_DIV(4)) u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .est_speed(est_speed),
      .est_angle(est_angle), .angle_out(angle_out), .forced_active(forced_active),
      .ctrl_tick(ctrl_tick), .params(params));

   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // top bit of coefficients one to three reads back as zero
   function automatic logic [7:0] msk(logic [15:0] i);
      if (i == efa_pkg::IDX_K1_HI || i == efa_pkg::IDX_K2_HI || i == efa_pkg::IDX_K3_HI)
         return 8'h7f;
      return 8'hff;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer; no cycle count assumed, the watchdog ends a hang
   task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] wd,
         input logic [7:0] e);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {14'h0000, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      if (!w)
         exp_q.push_back({24'h00_0000, e});
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   // drive the estimator side, let the registered select settle, then look
   task automatic sel(input logic [23:0] s, input logic [15:0] a, input logic f);
      @(posedge clk);
      est_speed <= s;
      est_angle <= a;
      repeat (2) @(posedge clk);
      #1;
      chk(32'(forced_active), 32'(f));
      if (!f)
         chk(32'(angle_out), 32'(a));
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // -----------------------------------------
   // read data monitor: oldest note against each completed read
   // -----------------------------------------
   always @(posedge clk) begin
      if (rd_pend && hreadyout === 1'b1) begin
         chk(hrdata, exp_q.pop_front());
         rd_pend <= 1'b0;
      end
      if (hsel && hready && htrans[1] && !hwrite)
         rd_pend <= 1'b1;
   end

   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // reset values, two unmapped places at the end of the run
      for (int i = 0; i < 16; i++)
         bus(1'b0, efa_pkg::IDX_INCR_HI + 16'(i), 8'h00, 8'h00);
      bus(1'b0, efa_pkg::IDX_CTRL, 8'h00, 8'h00);
      // all ones first, then random bytes, each read straight back
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 14; i++) begin
            idx = efa_pkg::IDX_INCR_HI + 16'(i);
            d = (p == 0) ? 8'hff : rnd[7:0];
            rnd = lfsr(rnd);
            bus(1'b1, idx, d, 8'h00);
            bus(1'b0, idx, 8'h00, d & msk(idx));
         end
      end
      bus(1'b1, 16'h4090, 8'h5a, 8'h00);
      bus(1'b0, 16'h4090, 8'h00, 8'h00);
      // threshold 0x0147, forced mode on: strictly-below boundary and a negative speed
      bus(1'b1, efa_pkg::IDX_THRESH_HI, 8'h01, 8'h00);
      bus(1'b1, efa_pkg::IDX_THRESH_LO, 8'h47, 8'h00);
      bus(1'b1, efa_pkg::IDX_CTRL, 8'h01, 8'h00);
      sel(24'h01_46ff, 16'h1234, 1'b1);
      sel(24'h01_4700, 16'h2345, 1'b0);
      sel(24'hff_0000, 16'h3456, 1'b1);
      // most negative threshold: nothing lies below it
      bus(1'b1, efa_pkg::IDX_THRESH_HI, 8'h80, 8'h00);
      bus(1'b1, efa_pkg::IDX_THRESH_LO, 8'h00, 8'h00);
      sel(24'h80_0000, 16'h4567, 1'b0);
      // ramp against a small ceiling, restarted from zero
      bus(1'b1, efa_pkg::IDX_THRESH_HI, 8'h7f, 8'h00);
      bus(1'b1, efa_pkg::IDX_CEIL_HI, 8'h00, 8'h00);
      bus(1'b1, efa_pkg::IDX_CEIL_LO, 8'h02, 8'h00);
      bus(1'b1, efa_pkg::IDX_INCR_HI, 8'h01, 8'h00);
      bus(1'b1, efa_pkg::IDX_INCR_LO, 8'h00, 8'h00);
      bus(1'b1, efa_pkg::IDX_CTRL, 8'h00, 8'h00);
      bus(1'b1, efa_pkg::IDX_CTRL, 8'h01, 8'h00);
      sel(24'h00_0000, 16'h0000, 1'b1);
      repeat (40) @(posedge clk);
      bus(1'b0, efa_pkg::IDX_STAT, 8'h00, 8'h03);
      bus(1'b0, efa_pkg::IDX_CTRL, 8'h00, 8'h01);
      // forced mode off: estimated angle wins even far below threshold
      bus(1'b1, efa_pkg::IDX_CTRL, 8'h00, 8'h00);
      sel(24'h80_0000, 16'h5678, 1'b0);
      repeat (2) @(posedge clk);
      wrap_up();
   end

   // hang guard, far beyond the few hundred cycles the scenarios take
   initial begin
      #400_000;
      bad_count++;
      wrap_up();
   end
endmodule // tb_efa_regs
